// ===== hcsgd_pkg.sv
// Purpose: Shared constants for the HID settings and direction command interpreter
// Assumes: 64-byte reports streamed one byte per cycle
// Notes: Byte positions are report indices
package hcsgd_pkg;
  localparam int unsigned HCSGD_RPT_LEN = 64;
  localparam int unsigned HCSGD_NPINS = 9;
  localparam logic [7:0] HCSGD_CMD_SET_CHIP = 8'h21;
  localparam logic [7:0] HCSGD_CMD_SET_DIR = 8'h32;
  localparam logic [7:0] HCSGD_CMD_GET_DIR = 8'h33;
  localparam logic [7:0] HCSGD_ST_OK = 8'h00;
  localparam logic [7:0] HCSGD_ST_UNKNOWN = 8'hFF;
  localparam logic [7:0] HCSGD_DES_GPIO = 8'h00;
  localparam logic [7:0] HCSGD_DES_CS = 8'h01;
  localparam logic [7:0] HCSGD_DES_DEDICATED = 8'h02;
  localparam logic [5:0] HCSGD_IDX_DES0 = 6'h04;
  localparam logic [5:0] HCSGD_IDX_DES8 = 6'h0C;
  localparam logic [5:0] HCSGD_IDX_DOUT_LO = 6'h0D;
  localparam logic [5:0] HCSGD_IDX_DOUT_HI = 6'h0E;
  localparam logic [5:0] HCSGD_IDX_DDIR_LO = 6'h0F;
  localparam logic [5:0] HCSGD_IDX_DDIR_HI = 6'h10;
  localparam logic [5:0] HCSGD_IDX_OTHER = 6'h11;
  localparam logic [5:0] HCSGD_IDX_DIR_LO = 6'h04;
  localparam logic [5:0] HCSGD_IDX_DIR_HI = 6'h05;
  localparam logic [5:0] HCSGD_IDX_STATUS = 6'h01;
  localparam logic [5:0] HCSGD_IDX_LAST = 6'h3F;
  localparam int unsigned HCSGD_BIT_WAKE = 4;
  localparam int unsigned HCSGD_BIT_BUSHOLD = 0;
  localparam int unsigned HCSGD_INTM_LSB = 1;
  localparam int unsigned HCSGD_INTM_MSB = 3;
  localparam logic [2:0] HCSGD_INTM_NONE = 3'h0;
  localparam logic [2:0] HCSGD_INTM_HIGHP = 3'h4;
  localparam logic [1:0] HCSGD_DES_RST = 2'h0;
  localparam logic [8:0] HCSGD_DIR_RST = 9'h1FF;
  localparam logic [8:0] HCSGD_DOUT_RST = 9'h000;
endpackage

// ===== hcsgd_pin_dir.sv
// Purpose: Per-pin current direction holder with designation gating
// Assumes: Update strobe comes from the same clock domain
// Notes: A pin not designated GPIO keeps its stored direction on a current load; a default load sets every pin
`timescale 1ns/1ps
module hcsgd_pin_dir
  import hcsgd_pkg::*;
#(
  parameter int unsigned NPINS = HCSGD_NPINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_default,
  input wire logic [NPINS-1:0] default_dir,
  input wire logic load_current,
  input wire logic [NPINS-1:0] new_dir,
  input wire logic [NPINS-1:0] is_gpio,
  output logic [NPINS-1:0] dir
);
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] dir_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next direction per pin; 1 means input
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    assign dir_d[i] = load_default ? default_dir[i] :
                      (load_current && is_gpio[i]) ? new_dir[i] : dir_q[i];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= HCSGD_DIR_RST;
    end else begin
      dir_q <= dir_d;
    end
  end

  assign dir = dir_q;
endmodule

// ===== hcsgd_cmd_interp.sv
// Purpose: HID command interpreter for volatile chip settings and GPIO directions
// Assumes: Command report arrives one byte per cycle, index 0 first, with a last flag on byte 63
// Notes: Response streams out after settings are applied; host must keep RSP_READY sensible
// Functional notes
// - Write-settings carries 0x21 in byte 0, zeros in 1..3 and pin 0..4 designations in bytes 4..8.
// - Bytes 9..12 designate pins 5..8: 0x00 GPIO, 0x01 chip select, 0x02 dedicated function.
// - Byte 13 holds default outputs of pins 7..0, bit 0 of byte 14 holds pin 8.
// - Bytes 15 and 16 hold default directions, low byte pins 7..0 and bit 0 of high byte pin 8.
// - Bit 4 of byte 17 enables remote wake-up when set.
// - Bits 3..1 of byte 17 pick the interrupt counting mode, codes 5..7 reserved.
// - Bit 0 of byte 17 set keeps the SPI bus between transfers, clear releases it.
// - Write-settings answer echoes 0x21 and a 0x00 status.
// - Direction-read answer echoes 0x33, status 0x00, pin 7..0 in byte 4 and pin 8 in byte 5 bit 0.
// - Direction writes touch only pins designated GPIO.
// - Direction-write request is 0x32 with directions in bytes 4 and 5.
// - Direction-write answer echoes 0x32 and a 0x00 status.
`timescale 1ns/1ps
module hcsgd_cmd_interp
  import hcsgd_pkg::*;
#(
  parameter int unsigned NPINS = HCSGD_NPINS
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_LAST,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_LAST,
  input wire logic RSP_READY,
  output logic [2*NPINS-1:0] PIN_DESIGNATION,
  output logic [NPINS-1:0] DEFAULT_OUTPUT,
  output logic [NPINS-1:0] DEFAULT_DIRECTION,
  output logic [NPINS-1:0] CURRENT_DIRECTION,
  output logic REMOTE_WAKE_EN,
  output logic [2:0] INT_COUNT_MODE,
  output logic SPI_BUS_HOLD
);
  typedef enum logic [1:0] {HCSGD_RX = 2'b00, HCSGD_APPLY = 2'b01, HCSGD_TX = 2'b11} hcsgd_state_t;

  hcsgd_state_t state_q, state_d;
  logic [5:0] idx_q;
  logic [7:0] cmd_q;
  logic [2*NPINS-1:0] des_q, des_sh_q;
  logic [NPINS-1:0] dout_q, dout_sh_q, ddir_q, ddir_sh_q, ndir_sh_q;
  logic [7:0] other_q, other_sh_q;
  logic [7:0] rsp_q;
  logic rsp_valid_q, rsp_last_q;
  logic [NPINS-1:0] dir_w;
  logic [NPINS-1:0] is_gpio;

  ////////////////////////////////////////////////////////////////////////////
  // Byte decode
  wire take = (state_q == HCSGD_RX) && CMD_VALID;
  wire at_des = (idx_q >= HCSGD_IDX_DES0) && (idx_q <= HCSGD_IDX_DES8);
  wire [3:0] des_pin = 4'(idx_q - HCSGD_IDX_DES0);
  wire rx_end = take && (CMD_LAST || idx_q == HCSGD_IDX_LAST);
  wire is_set = (cmd_q == HCSGD_CMD_SET_CHIP);
  wire is_sdir = (cmd_q == HCSGD_CMD_SET_DIR);
  wire is_gdir = (cmd_q == HCSGD_CMD_GET_DIR);
  wire do_apply = (state_q == HCSGD_APPLY);
  wire tx_go = (state_q == HCSGD_TX) && (!rsp_valid_q || RSP_READY);
  wire tx_done = (state_q == HCSGD_TX) && rsp_valid_q && RSP_READY && rsp_last_q;
  // Mode codes 5..7 are reserved; they are kept as given so a host read-back stays honest
  wire [2:0] intm_w = other_q[HCSGD_INTM_MSB:HCSGD_INTM_LSB];

  for (genvar p = 0; p < NPINS; p++) begin : g_gpio
    assign is_gpio[p] = (des_q[2*p +: 2] == HCSGD_DES_GPIO[1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response byte select: echo, status, then direction bytes
  wire [7:0] rsp_sel =
    (idx_q == 6'h00) ? cmd_q :
    (idx_q == HCSGD_IDX_STATUS) ? ((is_set || is_sdir || is_gdir) ? HCSGD_ST_OK : HCSGD_ST_UNKNOWN) :
    (is_gdir && idx_q == HCSGD_IDX_DIR_LO) ? dir_w[7:0] :
    (is_gdir && idx_q == HCSGD_IDX_DIR_HI) ? {7'h00, dir_w[8]} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HCSGD_RX: if (rx_end) state_d = HCSGD_APPLY;
      HCSGD_APPLY: state_d = HCSGD_TX;
      HCSGD_TX: if (tx_done) state_d = HCSGD_RX;
      default: state_d = HCSGD_RX;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= HCSGD_RX;
      idx_q <= 6'h00;
      cmd_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take) begin
        idx_q <= rx_end ? 6'h00 : 6'(idx_q + 6'h01);
        if (idx_q == 6'h00) cmd_q <= CMD_DATA;
      end else if (tx_done) begin
        // Must win over tx_go, which is also true on the final handshake
        idx_q <= 6'h00;
      end else if (tx_go) begin
        idx_q <= 6'(idx_q + 6'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow capture while the report streams in; bytes 1..3 and 18..63 are not checked
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      des_sh_q <= '0;
      dout_sh_q <= '0;
      ddir_sh_q <= '0;
      ndir_sh_q <= '0;
      other_sh_q <= 8'h00;
    end else if (take) begin
      if (at_des) des_sh_q[2*des_pin +: 2] <= CMD_DATA[1:0];
      if (idx_q == HCSGD_IDX_DOUT_LO) dout_sh_q[7:0] <= CMD_DATA;
      if (idx_q == HCSGD_IDX_DOUT_HI) dout_sh_q[8] <= CMD_DATA[0];
      if (idx_q == HCSGD_IDX_DDIR_LO) ddir_sh_q[7:0] <= CMD_DATA;
      if (idx_q == HCSGD_IDX_DDIR_HI) ddir_sh_q[8] <= CMD_DATA[0];
      if (idx_q == HCSGD_IDX_OTHER) other_sh_q <= CMD_DATA;
      if (idx_q == HCSGD_IDX_DIR_LO) ndir_sh_q[7:0] <= CMD_DATA;
      if (idx_q == HCSGD_IDX_DIR_HI) ndir_sh_q[8] <= CMD_DATA[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit to working settings one cycle before the first answer byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      des_q <= '0;
      dout_q <= HCSGD_DOUT_RST;
      ddir_q <= HCSGD_DIR_RST;
      other_q <= 8'h00;
    end else if (do_apply && is_set) begin
      des_q <= des_sh_q;
      dout_q <= dout_sh_q;
      ddir_q <= ddir_sh_q;
      other_q <= other_sh_q;
    end
  end

  // Current directions; a settings write reloads them from the defaults
  hcsgd_pin_dir #(.NPINS(NPINS)) u_dir (
    .clk(CLK),
    .rst_n(RST_N),
    .load_default(do_apply && is_set),
    .default_dir(ddir_sh_q),
    .load_current(do_apply && is_sdir),
    .new_dir(ndir_sh_q),
    .is_gpio(is_gpio),
    .dir(dir_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer stream register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= 8'h00;
      rsp_last_q <= 1'b0;
    end else if (tx_done) begin
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
    end else if (tx_go) begin
      rsp_valid_q <= 1'b1;
      rsp_q <= rsp_sel;
      rsp_last_q <= (idx_q == HCSGD_IDX_LAST);
    end
  end

  // Output flops; ready is held low once the sequencer leaves the receive state
  logic cmd_ready_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_ready_q <= 1'b0;
    end else begin
      cmd_ready_q <= (state_d == HCSGD_RX) && !rx_end;
    end
  end

  assign CMD_READY = cmd_ready_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA = rsp_q;
  assign RSP_LAST = rsp_last_q;
  assign PIN_DESIGNATION = des_q;
  assign DEFAULT_OUTPUT = dout_q;
  assign DEFAULT_DIRECTION = ddir_q;
  assign CURRENT_DIRECTION = dir_w;
  assign REMOTE_WAKE_EN = other_q[HCSGD_BIT_WAKE];
  assign INT_COUNT_MODE = intm_w;
  assign SPI_BUS_HOLD = other_q[HCSGD_BIT_BUSHOLD];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_ECHO: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == HCSGD_APPLY) |=> ##1 (rsp_valid_q && rsp_q == cmd_q)) else $error("Echo byte wrong");
  AST_APPLY_FIRST: assert property (@(posedge CLK) disable iff (!RST_N)
    (state_q == HCSGD_APPLY && is_set) |=> (des_q == $past(des_sh_q) && !rsp_valid_q)) else $error("Apply late");
  AST_WAKE: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_apply && is_set) |=> REMOTE_WAKE_EN == $past(other_sh_q[HCSGD_BIT_WAKE])) else $error("Wake bit wrong");
  // The next report must start again at byte 0 with its command code
  AST_RESTART: assert property (@(posedge CLK) disable iff (!RST_N)
    tx_done |=> (state_q == HCSGD_RX && idx_q == 6'h00)) else $error("Next report misaligned");
  AST_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_apply && is_set) |=> SPI_BUS_HOLD == $past(other_sh_q[0])) else $error("Bus hold wrong");
  AST_INTM: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_apply && is_set) |=> INT_COUNT_MODE == $past(other_sh_q[3:1])) else $error("Int mode wrong");
  AST_GATE: assert property (@(posedge CLK) disable iff (!RST_N)
    (do_apply && is_sdir) |=> ((dir_w ^ $past(dir_w)) & ~$past(is_gpio)) == '0) else $error("Non-GPIO pin moved");
  AST_DIRLO: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_go && is_gdir && idx_q == 6'h04) |=> rsp_q == dir_w[7:0]) else $error("Direction byte wrong");
  AST_STATUS: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_go && is_sdir && idx_q == 6'h01) |=> rsp_q == 8'h00) else $error("Status not success");
endmodule

// ===== hcsgd_host_model.sv
// Purpose: Host side model that sends one command report and collects its answer
// Assumes: Reports and answers are 64 bytes, one byte per handshake
// Notes: Signals change 2 ns after the rising edge
`timescale 1ns/1ps
module hcsgd_host_model (
  input wire logic clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_last,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_ready,
  input wire logic [8:0] cur_dir
);
  logic [7:0] rsp [64];
  logic [8:0] snap;
  logic [1:0] lastv; // Last flag on byte 63, last flag seen on any earlier byte
  ////////////////////
  // Idle host at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_last = 1'b0;
    rsp_ready = 1'b0;
  end
  ////////////////////
  // One report out, one answer back; slow stalls the answer side
  task automatic xfer(input logic [7:0] req [64], input bit slow);
    int i;
    int n;
    logic t;
    i = 0;
    n = 0;
    while (i < 64) begin
      cmd_valid = cmd_ready; // Offer a byte only while it can be taken
      cmd_data = req[i];
      cmd_last = (i == 63);
      t = cmd_valid;
      @(posedge clk);
      #2;
      if (t) i++;
    end
    // Released data line shows the inverse, so a stale byte is never mistaken
    cmd_valid = 1'b0;
    cmd_last = 1'b0;
    cmd_data = ~req[63];
    lastv = 2'b00;
    i = 0;
    while (i < 64) begin
      n++;
      rsp_ready = !slow || (n % 3 == 0);
      t = rsp_valid && rsp_ready;
      if (t) rsp[i] = rsp_data;
      if (t && i == 0) snap = cur_dir; // Working state seen as the answer starts
      if (t) lastv = (i == 63) ? {rsp_last, lastv[0]} : {lastv[1], lastv[0] | rsp_last};
      @(posedge clk);
      #2;
      if (t) i++;
    end
    rsp_ready = 1'b0;
  endtask
endmodule

// ===== hcsgd_cmd_interp_tb.sv
// Purpose: Self-checking bench for the settings and direction command interpreter
// Assumes: Host model drives the command side, bench works out expectations
// Notes: Random bytes come from an xorshift seeded with 68
`timescale 1ns/1ps
module hcsgd_cmd_interp_tb;
  import hcsgd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] cmd_data, rsp_data;
  logic [17:0] des, e18;
  logic [8:0] dout, ddir, cdir, cur;
  logic wake, hold;
  logic [2:0] mode;
  logic [31:0] v;
  logic [31:0] seed = 32'h0000_0044;
  logic [7:0] req [64];
  int errors = 0;
  int samples_checked = 0;
  ////////////////////
  // Clock at 25 ns
  always #12.5 clk = ~clk;
  hcsgd_cmd_interp i_hcsgd_cmd_interp (.CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid),
    .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_LAST(rsp_last), .RSP_READY(rsp_ready), .PIN_DESIGNATION(des),
    .DEFAULT_OUTPUT(dout), .DEFAULT_DIRECTION(ddir), .CURRENT_DIRECTION(cdir),
    .REMOTE_WAKE_EN(wake), .INT_COUNT_MODE(mode), .SPI_BUS_HOLD(hold));
  hcsgd_host_model i_hcsgd_host_model (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready), .cur_dir(cdir));
  ////////////////////
  // Helpers: random source, gating expectation, comparisons, verdict
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [8:0] gated(input logic [8:0] old, input logic [8:0] nw, input logic [17:0] d);
    logic [8:0] r;
    for (int p = 0; p < 9; p++) r[p] = (d[2*p+:2] == 2'h0) ? nw[p] : old[p];
    return r;
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input int idx, input logic [7:0] exp);
    chk(i_hcsgd_host_model.rsp[idx], exp);
  endtask
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic clr();
    foreach (req[i]) req[i] = 8'h00;
  endtask
  ////////////////////
  // Main sequence: every interrupt code, mixed and all-dedicated designations
  initial begin
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    @(posedge clk);
    #2;
    chk(des, 18'h0_0000);
    chk({dout, ddir}, {HCSGD_DOUT_RST, HCSGD_DIR_RST});
    chk({cdir, wake, mode, hold}, {HCSGD_DIR_RST, 5'h00});
    for (int k = 0; k < 8; k++) begin
      clr();
      req[0] = HCSGD_CMD_SET_CHIP;
      for (int p = 0; p < 9; p++) req[4+p] = (k == 1) ? HCSGD_DES_DEDICATED : 8'(rnd() % 3);
      for (int b = 13; b < 17; b++) req[b] = 8'(rnd());
      v = rnd();
      req[17] = {v[7:4], 3'(k), v[0]};
      for (int p = 0; p < 9; p++) e18[2*p+:2] = req[4+p][1:0];
      cur = {req[16][0], req[15]};
      i_hcsgd_host_model.xfer(req, k[0]);
      chkr(0, HCSGD_CMD_SET_CHIP);
      chkr(1, HCSGD_ST_OK);
      chk(i_hcsgd_host_model.lastv, 2'b10);
      chk(des, e18);
      chk(dout, {req[14][0], req[13]});
      chk({ddir, cdir}, {cur, cur});
      chk({wake, mode, hold}, {req[17][4], req[17][3:1], req[17][0]});
      chk(i_hcsgd_host_model.snap, cur);
      // Direction write, then read back
      clr();
      req[0] = HCSGD_CMD_SET_DIR;
      v = rnd();
      req[4] = v[7:0];
      req[5] = v[15:8];
      cur = gated(cur, {req[5][0], req[4]}, e18);
      i_hcsgd_host_model.xfer(req, !k[0]);
      chkr(0, HCSGD_CMD_SET_DIR);
      chkr(1, HCSGD_ST_OK);
      chk(cdir, cur);
      chk(i_hcsgd_host_model.snap, cur);
      clr();
      req[0] = HCSGD_CMD_GET_DIR;
      i_hcsgd_host_model.xfer(req, k[1]);
      chkr(0, HCSGD_CMD_GET_DIR);
      chkr(1, HCSGD_ST_OK);
      chk(i_hcsgd_host_model.lastv, 2'b10);
      chkr(4, cur[7:0]);
      chk(i_hcsgd_host_model.rsp[5][0], cur[8]);
    end
    // Mid-run reset: every setting returns to its reset value, all pins back to GPIO
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    @(posedge clk);
    #2;
    cur = HCSGD_DIR_RST;
    chk(des, 18'h0_0000);
    chk({dout, ddir}, {HCSGD_DOUT_RST, HCSGD_DIR_RST});
    chk({cdir, wake, mode, hold}, {HCSGD_DIR_RST, 5'h00});
    // Direction write with every pin GPIO, pin 8 turned to output
    clr();
    req[0] = HCSGD_CMD_SET_DIR;
    req[4] = 8'h5A;
    cur = gated(cur, {req[5][0], req[4]}, 18'h0_0000);
    i_hcsgd_host_model.xfer(req, 1'b1);
    chkr(0, HCSGD_CMD_SET_DIR);
    chk(i_hcsgd_host_model.lastv, 2'b10);
    chk(cdir, cur);
    // Unlisted code is echoed with a failure status and changes nothing
    clr();
    req[0] = 8'h31;
    i_hcsgd_host_model.xfer(req, 1'b0);
    chkr(0, 8'h31);
    chkr(1, HCSGD_ST_UNKNOWN);
    chk(cdir, cur);
    test_done();
  end
  ////////////////////
  // Watchdog: about four times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    test_done();
  end
endmodule
